// file: design/tsdc_pkg.sv
package tsdc_pkg;
    // Bus address choices from the select pin
    localparam logic [6:0] TSDC_ADDR_GND = 7'h50;
    localparam logic [6:0] TSDC_ADDR_OPEN = 7'h40;
    localparam logic [6:0] TSDC_ADDR_HIGH = 7'h42;
    // Control byte field positions
    localparam int TSDC_CTL_BIL_LO = 0;
    localparam int TSDC_CTL_BIL_HI = 1;
    localparam int TSDC_CTL_MONO = 2;
    localparam int TSDC_CTL_MUTE = 3;
    localparam int TSDC_CTL_AUX = 4;
    localparam int TSDC_CTL_SQW = 5;
    localparam int TSDC_CTL_DIRECT = 6;
    localparam int TSDC_CTL_TEST = 7;
    localparam logic [7:0] TSDC_CTL_RESET = 8'h01;
    // Status byte positions
    localparam int TSDC_ST_STEREO = 7;
    localparam int TSDC_ST_BIL = 6;
    localparam int TSDC_ST_INIT = 5;
    // Three-level pin codes
    typedef enum logic [1:0] {TSDC_LVL_LOW, TSDC_LVL_OPEN, TSDC_LVL_HIGH} tsdc_lvl_t;
    // Broadcast type codes
    typedef enum logic [1:0] {TSDC_BT_STEREO, TSDC_BT_MONO, TSDC_BT_BIL} tsdc_bt_t;
    // Square wave: 400 Hz output period in us
    localparam int TSDC_SQW_PERIOD_US = 2500;
    localparam int TSDC_CLK_MHZ = 20;
    localparam int TSDC_SQW_HALF_CYC = TSDC_SQW_PERIOD_US * TSDC_CLK_MHZ / 2;
    // APB register offsets
    localparam logic [11:0] TSDC_OFF_CTRL = 12'h000;
    localparam logic [11:0] TSDC_OFF_STAT = 12'h004;
    localparam logic [11:0] TSDC_OFF_IRQ = 12'h008;
    localparam logic [11:0] TSDC_OFF_MASK = 12'h00c;
    // Interrupt event bits
    localparam int TSDC_EV_WRITE = 0;
    localparam int TSDC_EV_READ = 1;
    localparam int TSDC_EV_ABORT = 2;
    localparam int TSDC_EV_BTCHG = 3;
endpackage

// file: design/tsdc_sync.sv
`timescale 1ns/1ns
module tsdc_sync
    import tsdc_pkg::*;
#(
    parameter int W = 2,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tsdc_sync_st_t;
    tsdc_sync_st_t st_r;
    tsdc_sync_st_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= {INIT, INIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

// file: design/tsdc_sqw.sv
`timescale 1ns/1ns
module tsdc_sqw
    import tsdc_pkg::*;
#(
    parameter int HALF = TSDC_SQW_HALF_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    output logic sqw_oe
);
    typedef struct packed {
        logic [23:0] cnt;
        logic ph;
    } tsdc_sqw_st_t;
    tsdc_sqw_st_t st_r;
    tsdc_sqw_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!enable) begin
            st_nxt.cnt = '0;
            st_nxt.ph = 1'b0;
        end else if (st_r.cnt == 24'(HALF - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.ph = !st_r.ph;
        end else begin
            st_nxt.cnt = st_r.cnt + 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Open collector: pull low in phase one only
    assign sqw_oe = st_r.ph;
endmodule

// file: design/tsdc_top.sv
`timescale 1ns/1ns
// Contract
// [R1] Start: data falls while clock high
// [R2] Stop: data rises while clock high
// [R3] Host sends bytes MSB first
// [R4] Ninth clock: device pulls data low
// [R5] Address pattern is 1000000 plus direction; code uses it only with the select pin open
// [R6] Seven address bits, eighth gives direction
// [R7] Write: address, ack, control byte, ack
// [R8] Stop mid-byte discards the partial byte
// [R9] Read: address, ack, status byte out
// [R10] Host supplies nine clocks for read
// [R11] Mute pin three levels decoded
// [R12] Broadcast type shown as three levels
// [R13] Open-collector square wave when enabled
// [R14] Select pin picks one of three addresses
// [R15] Control byte field meanings
// [R16] Status byte: stereo, bilingual, initial flag
// [R17] Control byte resets to 01h
// [R18] No ack on address mismatch
// [R19] Sample on rise, change while low
module tsdc_top
    import tsdc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire tsdc_lvl_t addr_sel,
    input wire tsdc_lvl_t mute_level,
    input wire logic stereo_found,
    input wire logic bilingual_found,
    output logic out_muted,
    output logic area_control,
    output tsdc_bt_t broadcast_type_level_out,
    output logic [1:0] bilingual_sel,
    output logic force_mono,
    output logic aux_line_source,
    output logic direct_input,
    output logic test_mode,
    output logic sqw_o,
    output logic sqw_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        TSDC_IDLE, TSDC_ADDR, TSDC_AACK, TSDC_WDATA, TSDC_WACK, TSDC_RDATA, TSDC_RACK
    } tsdc_state_t;

    typedef struct packed {
        tsdc_state_t state;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ctrl;
        logic init;
        logic drive_low;
        logic scl_d;
        logic sda_d;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        tsdc_bt_t bt;
        logic [31:0] rdata;
    } tsdc_st_t;

    tsdc_st_t st_r;
    tsdc_st_t st_nxt;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [6:0] my_addr;
    logic [3:0] ev;
    tsdc_bt_t bt_now;
    logic [5:0] det_s;
    logic stereo_s;
    logic bil_s;
    tsdc_lvl_t mute_s;
    tsdc_lvl_t sel_s;
    logic [7:0] status_byte;
    logic apb_wr;
    logic wr_ctrl;
    logic wr_irq;
    logic wr_mask;

    // Pins cross into clk domain first
    // Idle-high reset, so no false edge after reset
    tsdc_sync #(.W(2), .INIT(2'b11)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({scl_i, sda_i}),
        .q(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Detector and level pins, reset to open levels
    tsdc_sync #(.W(6), .INIT(6'h05)) u_sync_det (
        .clk(clk),
        .resetn(resetn),
        .d({stereo_found, bilingual_found, mute_level, addr_sel}),
        .q(det_s)
    );
    assign stereo_s = det_s[5];
    assign bil_s = det_s[4];
    assign mute_s = tsdc_lvl_t'(det_s[3:2]);
    assign sel_s = tsdc_lvl_t'(det_s[1:0]);
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    // Edges seen two clocks late, after the sync
    assign scl_rise = scl_s && !st_r.scl_d;
    assign scl_fall = !scl_s && st_r.scl_d;
    // [R1] Start detect
    assign start_ev = scl_s && st_r.scl_d && st_r.sda_d && !sda_s;
    // [R2] Stop detect
    assign stop_ev = scl_s && st_r.scl_d && !st_r.sda_d && sda_s;

    // [R14] Address from select pin
    // Pin is static in use, but still synchronised
    always_comb begin
        unique case (sel_s)
            TSDC_LVL_LOW: my_addr = TSDC_ADDR_GND;
            TSDC_LVL_HIGH: my_addr = TSDC_ADDR_HIGH;
            default: my_addr = TSDC_ADDR_OPEN;
        endcase
    end

    // [R12] Broadcast type from detectors
    always_comb begin
        if (bil_s) begin
            bt_now = TSDC_BT_BIL;
        end else if (stereo_s) begin
            bt_now = TSDC_BT_STEREO;
        end else begin
            bt_now = TSDC_BT_MONO;
        end
    end

    // [R16] Status byte, low five bits fixed low
    always_comb begin
        status_byte = {stereo_s, bil_s, st_r.init, 5'h00};
    end

    // Writes land in the access phase
    always_comb begin
        apb_wr = psel && penable && pwrite;
        wr_ctrl = apb_wr && (paddr == TSDC_OFF_CTRL);
        wr_irq = apb_wr && (paddr == TSDC_OFF_IRQ);
        wr_mask = apb_wr && (paddr == TSDC_OFF_MASK);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        ev = '0;
        st_nxt.scl_d = scl_s;
        st_nxt.sda_d = sda_s;
        // Type is registered to stay glitch free
        st_nxt.bt = bt_now;
        if (bt_now != st_r.bt) begin
            ev[TSDC_EV_BTCHG] = 1'b1;
        end
        if (stop_ev) begin
            // [R8] Partial byte dropped
            // The clock before a stop shifts one bit too, so only more marks a cut byte
            if (st_r.state == TSDC_WDATA && st_r.bitcnt > 4'h1) begin
                ev[TSDC_EV_ABORT] = 1'b1;
            end
            st_nxt.state = TSDC_IDLE;
            st_nxt.drive_low = 1'b0;
        end else if (start_ev) begin
            // Repeated start also restarts the address phase
            st_nxt.state = TSDC_ADDR;
            st_nxt.bitcnt = '0;
            st_nxt.drive_low = 1'b0;
        end else if (scl_rise) begin
            // [R19] Sample on rising clock
            unique case (st_r.state)
                TSDC_ADDR, TSDC_WDATA: begin
                    // Bit count also marks a cut byte on stop
                    // [R3] MSB first shift
                    st_nxt.shift = {st_r.shift[6:0], sda_s};
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                end
                TSDC_RDATA: begin
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                end
                TSDC_RACK: begin
                    // Host nack ends output; ack also ends single byte
                    st_nxt.state = TSDC_IDLE;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            // [R19] Change data while clock low
            unique case (st_r.state)
                TSDC_ADDR: begin
                    // Address phase counts eight rising edges
                    if (st_r.bitcnt == 4'h8) begin
                        // [R5] [R6] Match address, direction in bit 0
                        if (st_r.shift[7:1] == my_addr) begin
                            // [R4] Acknowledge the address
                            st_nxt.drive_low = 1'b1;
                            st_nxt.state = TSDC_AACK;
                        end else begin
                            // [R18] Mismatch stays released
                            st_nxt.state = TSDC_IDLE;
                        end
                    end
                end
                TSDC_AACK: begin
                    st_nxt.bitcnt = '0;
                    if (st_r.shift[0]) begin
                        // [R9] [R16] Load status byte, first bit out
                        // Status sampled once, so it cannot change mid-byte
                        st_nxt.shift = status_byte;
                        st_nxt.drive_low = !status_byte[TSDC_ST_STEREO];
                        st_nxt.state = TSDC_RDATA;
                        st_nxt.init = 1'b0;
                        ev[TSDC_EV_READ] = 1'b1;
                    end else begin
                        st_nxt.drive_low = 1'b0;
                        st_nxt.state = TSDC_WDATA;
                    end
                end
                TSDC_WDATA: begin
                    if (st_r.bitcnt == 4'h8) begin
                        // [R7] [R15] Commit control byte, then ack
                        st_nxt.ctrl = st_r.shift;
                        st_nxt.drive_low = 1'b1;
                        st_nxt.state = TSDC_WACK;
                        ev[TSDC_EV_WRITE] = 1'b1;
                    end
                end
                TSDC_WACK: begin
                    // Further bytes are taken as new control bytes
                    st_nxt.drive_low = 1'b0;
                    st_nxt.bitcnt = '0;
                    st_nxt.state = TSDC_WDATA;
                end
                TSDC_RDATA: begin
                    // [R10] Ninth clock releases for host ack
                    if (st_r.bitcnt == 4'h8) begin
                        st_nxt.drive_low = 1'b0;
                        st_nxt.state = TSDC_RACK;
                    end else begin
                        // Shift on the fall so the bit is steady at the rise
                        st_nxt.shift = {st_r.shift[6:0], 1'b0};
                        st_nxt.drive_low = !st_r.shift[6];
                    end
                end
                default: begin
                end
            endcase
        end
        // Set wins over clear
        if (wr_irq) begin
            st_nxt.irq_stat = (st_r.irq_stat & ~pwdata[3:0]) | ev;
        end else begin
            st_nxt.irq_stat = st_r.irq_stat | ev;
        end
        if (wr_mask) begin
            st_nxt.irq_mask = pwdata[3:0];
        end
        // A bus write in the same cycle as a serial commit wins
        if (wr_ctrl) begin
            st_nxt.ctrl = pwdata[7:0];
        end
        // Read data registered from the setup-phase address
        unique case (paddr)
            TSDC_OFF_CTRL: st_nxt.rdata = {24'h000000, st_r.ctrl};
            TSDC_OFF_STAT: st_nxt.rdata = {24'h000000, status_byte};
            TSDC_OFF_IRQ: st_nxt.rdata = {28'h0000000, st_r.irq_stat};
            TSDC_OFF_MASK: st_nxt.rdata = {28'h0000000, st_r.irq_mask};
            default: st_nxt.rdata = '0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.state <= TSDC_IDLE;
            st_r.bt <= TSDC_BT_MONO;
            // Idle-high history avoids a false edge
            st_r.scl_d <= 1'b1;
            st_r.sda_d <= 1'b1;
            st_r.init <= 1'b1;
            // [R17] Power-up control value
            st_r.ctrl <= TSDC_CTL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open drain: only ever pulls low
    // Never drive high: the bus is wired-and
    assign sda_o = 1'b0;
    assign sda_oe = st_r.drive_low;

    // [R11] Mute pin levels, high level overrides
    assign out_muted = (mute_s == TSDC_LVL_HIGH) || st_r.ctrl[TSDC_CTL_MUTE];
    // Ground level adds detection-area control
    assign area_control = (mute_s == TSDC_LVL_LOW);
    // The analog level drive itself sits outside
    assign broadcast_type_level_out = st_r.bt;
    // [R15] Control fields
    assign bilingual_sel = st_r.ctrl[TSDC_CTL_BIL_HI:TSDC_CTL_BIL_LO];
    assign force_mono = st_r.ctrl[TSDC_CTL_MONO];
    assign aux_line_source = st_r.ctrl[TSDC_CTL_AUX];
    assign direct_input = st_r.ctrl[TSDC_CTL_DIRECT];
    assign test_mode = st_r.ctrl[TSDC_CTL_TEST];

    // [R13] Square wave on open-collector pin
    tsdc_sqw u_sqw (
        .clk(clk),
        .resetn(resetn),
        .enable(st_r.ctrl[TSDC_CTL_SQW]),
        .sqw_oe(sqw_oe)
    );
    // Open collector: the high level comes from the pull-up
    assign sqw_o = 1'b0;

    // APB: zero wait, unmapped reads zero
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_r.rdata;
    // Level interrupt while any unmasked event is pending
    assign irq = |(st_r.irq_stat & st_r.irq_mask);
endmodule

// file: tb/tsdc_props.sv
`timescale 1ns/1ns
module tsdc_props
    import tsdc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire tsdc_lvl_t mute_level,
    input wire logic out_muted,
    input wire logic area_control,
    input wire logic stereo_found,
    input wire logic bilingual_found,
    input wire tsdc_bt_t broadcast_type_level_out,
    input wire logic sqw_o,
    input wire logic sqw_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    a_ack_pulls_low: assert property (sda_oe |-> !sda_o)
        else $error("data line driven high");
    a_data_held_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("data moved while clock high");
    // Pins pass a two-flop sync, so levels get five cycles to settle
    a_mute_pin_high: assert property (
        (mute_level == TSDC_LVL_HIGH)[*5] |-> out_muted)
        else $error("mute pin ignored");
    a_area_on_ground: assert property (
        (mute_level == TSDC_LVL_LOW)[*5] |-> area_control)
        else $error("area control missing");
    a_area_off_open: assert property (
        (mute_level != TSDC_LVL_LOW)[*5] |-> !area_control)
        else $error("area control stray");
    a_type_bil: assert property (
        bilingual_found[*5] |-> broadcast_type_level_out == TSDC_BT_BIL)
        else $error("type not bilingual");
    a_type_stereo: assert property (
        (stereo_found && !bilingual_found)[*5] |-> broadcast_type_level_out == TSDC_BT_STEREO)
        else $error("type not stereo");
    a_type_mono: assert property (
        (!stereo_found && !bilingual_found)[*5] |-> broadcast_type_level_out == TSDC_BT_MONO)
        else $error("type not mono");
    a_square_open: assert property (!sqw_o)
        else $error("square pin driven high");
    a_drive_clock_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data drive began with clock high");
    a_square_slow: assert property ($changed(sqw_oe) |=> $stable(sqw_oe)[*8])
        else $error("square wave toggles too fast");
    c_ack: cover property ($rose(sda_oe));
    c_muted: cover property (out_muted && !area_control);
    c_bil: cover property (broadcast_type_level_out == TSDC_BT_BIL);
endmodule
bind tsdc_top tsdc_props i_tsdc_props (.*);

// file: tb/tsdc_host.sv
`timescale 1ns/1ns
module tsdc_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////
    // One bit, 200 ns a phase
    task automatic bitx(input logic b, output logic r);
        scl <= 1'b0;
        @(posedge clk);
        sda_low <= !b;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        r = sda;
    endtask
    task automatic start();
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic stop();
        logic r;
        bitx(1'b0, r);
        sda_low <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
        output logic r9);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(nine, r9);
    endtask
endmodule

// file: tb/tsdc_top_bench.sv
`timescale 1ns/1ns
module tsdc_top_bench
    import tsdc_pkg::*;
;
    logic clk, resetn, scl_i, sda_i, host_low, sda_o, sda_oe, r9, last;
    logic stereo_found, bilingual_found, out_muted, area_control, force_mono;
    logic aux_line_source, direct_input, test_mode, sqw_o, sqw_oe;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [1:0] bilingual_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] q;
    logic [6:0] addr_tab [3] = '{7'h50, 7'h40, 7'h42};
    tsdc_lvl_t addr_sel, mute_level;
    tsdc_bt_t broadcast_type_level_out;
    int failures, tests_run, seed, ctrl_m, init_m, cnt;
    // Pull-up: a released line reads high
    assign sda_i = !(host_low || sda_oe);
    tsdc_top i_tsdc_top (.*);
    tsdc_host i_tsdc_host (.clk(clk), .sda(sda_i), .scl(scl_i), .sda_low(host_low));
    ////////////////////////////////////////
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic chk_ctrl();
        logic [7:0] p;
        apb(1'b0, TSDC_OFF_CTRL, 32'h0);
        p = {test_mode, direct_input, 1'b0, aux_line_source, 1'b0, force_mono, bilingual_sel};
        check("ctrl reg", rd, ctrl_m);
        check("ctrl pins", p, ctrl_m & 'hd7);
    endtask
    task automatic i2c_wr(input logic [6:0] a, input logic [7:0] d, input logic hit);
        i_tsdc_host.start();
        i_tsdc_host.xfer({a, 1'b0}, 1'b1, q, r9);
        check("addr ack", r9, !hit);
        if (hit) begin
            i_tsdc_host.xfer(d, 1'b1, q, r9);
            check("data ack", r9, 1'b0);
            ctrl_m = d;
        end
        i_tsdc_host.stop();
    endtask
    task automatic sqw_gap();
        cnt = 0;
        last = sqw_oe;
        while (sqw_oe === last && cnt < 30000) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 30000) begin
            failures++;
            give_verdict();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        seed = 32981;
        resetn = 1'b0;
        {psel, penable, pwrite, stereo_found, bilingual_found} = '0;
        paddr = '0;
        pwdata = '0;
        addr_sel = TSDC_LVL_OPEN;
        mute_level = TSDC_LVL_OPEN;
        ctrl_m = 1;
        init_m = 1;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk_ctrl();
        for (int s = 0; s < 3; s++) begin
            addr_sel <= tsdc_lvl_t'(s);
            repeat (4) @(posedge clk);
            i2c_wr(addr_tab[(s + 1) % 3], 8'h04, 1'b0);
            i2c_wr(addr_tab[s], 8'($random(seed)) & 8'h5d, 1'b1);
            chk_ctrl();
        end
        addr_sel <= TSDC_LVL_OPEN;
        for (int m = 0; m < 3; m++) begin
            mute_level <= tsdc_lvl_t'(m);
            repeat (6) @(posedge clk);
            check("mute", out_muted, m == 2 || ctrl_m[3]);
            check("area", area_control, m == 0);
        end
        mute_level <= TSDC_LVL_OPEN;
        // Partial byte then stop must leave settings alone
        i_tsdc_host.start();
        i_tsdc_host.xfer(8'h80, 1'b1, q, r9);
        repeat (4) i_tsdc_host.bitx(1'b1, r9);
        i_tsdc_host.stop();
        chk_ctrl();
        apb(1'b0, TSDC_OFF_IRQ, 32'h0);
        check("abort event", rd, 32'h5);
        for (int k = 0; k < 4; k++) begin
            stereo_found <= k[0];
            bilingual_found <= k[1];
            repeat (6) @(posedge clk);
            check("type", broadcast_type_level_out, k[1] ? 2 : (k[0] ? 0 : 1));
            i_tsdc_host.start();
            i_tsdc_host.xfer(8'h81, 1'b1, q, r9);
            check("read ack", r9, 1'b0);
            i_tsdc_host.xfer(8'hff, 1'b0, q, r9);
            check("status", q, {k[0], k[1], init_m[0], 5'h0});
            init_m = 0;
            i_tsdc_host.stop();
        end
        apb(1'b1, TSDC_OFF_MASK, 32'h0);
        apb(1'b1, TSDC_OFF_IRQ, 32'hf);
        i2c_wr(7'h40, 8'h01, 1'b1);
        apb(1'b0, TSDC_OFF_IRQ, 32'h0);
        check("events", rd, 32'h1);
        check("irq masked", irq, 1'b0);
        apb(1'b1, TSDC_OFF_MASK, 32'h1);
        check("irq on", irq, 1'b1);
        apb(1'b1, TSDC_OFF_IRQ, 32'h1);
        check("irq off", irq, 1'b0);
        apb(1'b1, 12'h010, 32'hff);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", rd, 32'h0);
        apb(1'b1, TSDC_OFF_CTRL, 32'h21);
        ctrl_m = 'h21;
        chk_ctrl();
        // First gap is partial, the second is a full half period
        sqw_gap();
        sqw_gap();
        check("sqw half", cnt, TSDC_SQW_HALF_CYC);
        give_verdict();
    end
endmodule
